/* bsf_pkg.sv */
// constants, commands and register map for the shift/bit/flag datapath
// assumes a byte-wide core with an 8-bit status word and APB register access
package bsf_pkg;

    // register byte addresses
    localparam logic [7:0] CMD_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] FLAGS_ADDR = 8'h08;
    localparam logic [7:0] GPR_IDX_ADDR = 8'h0c;
    localparam logic [7:0] GPR_DATA_ADDR = 8'h10;
    localparam logic [7:0] IO_IDX_ADDR = 8'h14;
    localparam logic [7:0] IO_DATA_ADDR = 8'h18;
    localparam logic [7:0] STACK_DATA_ADDR = 8'h1c;
    localparam logic [7:0] SP_ADDR = 8'h20;

    // command and status word field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_REG_LSB = 4;
    localparam int CMD_BIT_LSB = 9;
    localparam int CMD_IO_LSB = 12;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_FLAGS_LSB = 8;

    // status flags word bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // sizes and reset values
    localparam int GPR_COUNT = 32;
    localparam int IO_COUNT = 64;
    localparam int STACK_DEPTH = 16;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [3:0] SP_RESET = 4'hf;

    // execution lengths in clock cycles
    localparam int SHORT_OP_CYCLES = 1;
    localparam int LONG_OP_CYCLES = 2;

    typedef enum logic [3:0] {
        nop_op = 4'h0,
        stack_pop_op = 4'h1,
        io_bit_set_op = 4'h2,
        io_bit_clear_op = 4'h3,
        logical_left_shift_op = 4'h4,
        logical_right_shift_op = 4'h5,
        rotate_left_carry_op = 4'h6,
        rotate_right_carry_op = 4'h7,
        arith_right_shift_op = 4'h8,
        nibble_swap_op = 4'h9,
        bit_to_transfer_flag_op = 4'ha,
        transfer_flag_to_bit_op = 4'hb,
        flag_force_one_op = 4'hc,
        flag_force_zero_op = 4'hd
    } op_t;

    typedef enum {
        st_idle,
        st_stage_a,
        st_stage_b
    } seq_state_t;

endpackage

/* exec_if.sv */
// signals between the datapath top, its sequencer and its shift/flag unit
// assumes all three sit on the same clock
interface exec_if;
    import bsf_pkg::*;
    logic start;
    logic long_op;
    logic busy;
    logic stage_a;
    logic stage_b;
    op_t op;
    logic [7:0] operand;
    logic [7:0] flags_in;
    logic [2:0] bit_sel;
    logic [7:0] result;
    logic [7:0] flags_out;

    modport seq_mp (input start, input long_op, output busy, output stage_a, output stage_b);
    modport alu_mp (input op, input operand, input flags_in, input bit_sel, output result, output flags_out);
    modport top_mp (output start, output long_op, input busy, input stage_a, input stage_b,
                    output op, output operand, output flags_in, output bit_sel,
                    input result, input flags_out);
endinterface

/* bsf_alu.sv */
// combinational result and flag unit for shifts, rotates, swap and bit moves
// assumes the caller commits result and flags only in the execute cycle
module bsf_alu
    import bsf_pkg::*;
(
    exec_if.alu_mp ex
);
    logic carry_out;
    logic shift_op;

    // ----------------------------------------
    // result and flag computation
    // ----------------------------------------
    always_comb
    begin
        ex.result = ex.operand;
        ex.flags_out = ex.flags_in;
        carry_out = ex.flags_in[FLAG_C];
        shift_op = 1'b1;
        unique case (ex.op)
            logical_left_shift_op:
            begin
                ex.result = {ex.operand[6:0], 1'b0};
                carry_out = ex.operand[7];
            end
            logical_right_shift_op:
            begin
                ex.result = {1'b0, ex.operand[7:1]};
                carry_out = ex.operand[0];
            end
            rotate_left_carry_op:
            begin
                ex.result = {ex.operand[6:0], ex.flags_in[FLAG_C]};
                carry_out = ex.operand[7];
            end
            rotate_right_carry_op:
            begin
                ex.result = {ex.flags_in[FLAG_C], ex.operand[7:1]};
                carry_out = ex.operand[0];
            end
            arith_right_shift_op:
            begin
                ex.result = {ex.operand[7], ex.operand[7:1]};
                carry_out = ex.operand[0];
            end
            default:
            begin
                shift_op = 1'b0;
            end
        endcase
        // shifts share one flag update; s, h, t and i stay put
        if (shift_op)
        begin
            ex.flags_out[FLAG_C] = carry_out;
            ex.flags_out[FLAG_Z] = (ex.result == 8'h00);
            ex.flags_out[FLAG_N] = ex.result[7];
            ex.flags_out[FLAG_V] = ex.result[7] ^ carry_out;
        end
        unique case (ex.op)
            nibble_swap_op: ex.result = {ex.operand[3:0], ex.operand[7:4]};
            bit_to_transfer_flag_op: ex.flags_out[FLAG_T] = ex.operand[ex.bit_sel];
            transfer_flag_to_bit_op: ex.result[ex.bit_sel] = ex.flags_in[FLAG_T];
            flag_force_one_op: ex.flags_out[ex.bit_sel] = 1'b1;
            flag_force_zero_op: ex.flags_out[ex.bit_sel] = 1'b0;
            default:
            begin
            end
        endcase
    end
endmodule

/* bsf_seq.sv */
// cycle sequencer: one execute stage for short operations, two for long ones
// assumes start is only raised while busy is low
module bsf_seq
    import bsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    exec_if.seq_mp ex
);
    seq_state_t state_ff;
    seq_state_t nxt_state;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            st_idle: if (ex.start) nxt_state = st_stage_a;
            st_stage_a: nxt_state = ex.long_op ? st_stage_b : st_idle;
            st_stage_b: nxt_state = st_idle;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= st_idle;
        else
            state_ff <= nxt_state;
    end

    // decoded stage strobes
    assign ex.busy = (state_ff != st_idle);
    assign ex.stage_a = (state_ff == st_stage_a);
    assign ex.stage_b = (state_ff == st_stage_b);
endmodule

/* bsf_top.sv */
// apb-reached execution datapath for pop, i/o bit, shift, bit-move and flag operations
// assumes an apb master on pclk; commands arrive as writes to the command register
//
// Added by the designer: the APB slave port and the address map.
module bsf_top
    import bsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import bsf_pkg::*;

    exec_if ex ();

    // ----------------------------------------
    // state declarations
    // ----------------------------------------
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    op_t op_ff;
    op_t nxt_op;
    logic [4:0] reg_ff;
    logic [4:0] nxt_reg;
    logic [2:0] bit_ff;
    logic [2:0] nxt_bit;
    logic [5:0] io_ff;
    logic [5:0] nxt_io;

    logic [4:0] gpr_idx_ff;
    logic [4:0] nxt_gpr_idx;
    logic [5:0] io_idx_ff;
    logic [5:0] nxt_io_idx;
    logic [3:0] sp_ff;
    logic [3:0] nxt_sp;
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    logic [7:0] gpr_mem [GPR_COUNT];
    logic [7:0] io_mem [IO_COUNT];
    logic [7:0] stack_mem [STACK_DEPTH];

    logic gpr_we;
    logic [4:0] gpr_wa;
    logic [7:0] gpr_wd;
    logic io_we;
    logic [5:0] io_wa;
    logic [7:0] io_wd;
    logic stack_we;
    logic [3:0] stack_wa;
    logic [7:0] stack_wd;

    logic setup;
    logic wr_acc;
    logic cmd_wr;
    logic data_wr;
    logic mapped;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // a write lands only at the access edge where pready is seen high
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_ff & pwrite;
    assign cmd_wr = wr_acc & (paddr == CMD_ADDR) & ~ex.busy;
    // data writes are refused mid-operation so the bus never races the datapath
    assign data_wr = wr_acc & ~ex.busy;

    // address map membership
    always_comb
    begin
        unique case (paddr)
            CMD_ADDR, STATUS_ADDR, FLAGS_ADDR, GPR_IDX_ADDR, GPR_DATA_ADDR,
            IO_IDX_ADDR, IO_DATA_ADDR, STACK_DATA_ADDR, SP_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // read mux and handshake, both prepared in the setup cycle
    always_comb
    begin
        nxt_pready = setup;
        nxt_pslverr = setup & ~mapped;
        nxt_prdata = 32'h0000_0000;
        if (setup & ~pwrite)
        begin
            unique case (paddr)
                CMD_ADDR:
                begin
                    nxt_prdata[CMD_OP_LSB +: 4] = op_ff;
                    nxt_prdata[CMD_REG_LSB +: 5] = reg_ff;
                    nxt_prdata[CMD_BIT_LSB +: 3] = bit_ff;
                    nxt_prdata[CMD_IO_LSB +: 6] = io_ff;
                end
                STATUS_ADDR:
                begin
                    nxt_prdata[STATUS_BUSY_BIT] = ex.busy;
                    nxt_prdata[STATUS_FLAGS_LSB +: 8] = flags_ff;
                end
                FLAGS_ADDR: nxt_prdata[7:0] = flags_ff;
                GPR_IDX_ADDR: nxt_prdata[4:0] = gpr_idx_ff;
                GPR_DATA_ADDR: nxt_prdata[7:0] = gpr_mem[gpr_idx_ff];
                IO_IDX_ADDR: nxt_prdata[5:0] = io_idx_ff;
                IO_DATA_ADDR: nxt_prdata[7:0] = io_mem[io_idx_ff];
                STACK_DATA_ADDR: nxt_prdata[7:0] = stack_mem[sp_ff];
                SP_ADDR: nxt_prdata[3:0] = sp_ff;
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ----------------------------------------
    // command capture
    // ----------------------------------------
    // unknown op codes fall back to no operation
    always_comb
    begin
        nxt_op = op_ff;
        nxt_reg = reg_ff;
        nxt_bit = bit_ff;
        nxt_io = io_ff;
        if (cmd_wr)
        begin
            nxt_op = (pwdata[CMD_OP_LSB +: 4] > flag_force_zero_op) ? nop_op : op_t'(pwdata[CMD_OP_LSB +: 4]);
            nxt_reg = pwdata[CMD_REG_LSB +: 5];
            nxt_bit = pwdata[CMD_BIT_LSB +: 3];
            nxt_io = pwdata[CMD_IO_LSB +: 6];
        end
    end

    // command registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_ff <= nop_op;
            reg_ff <= 5'h00;
            bit_ff <= 3'h0;
            io_ff <= 6'h00;
        end
        else
        begin
            op_ff <= nxt_op;
            reg_ff <= nxt_reg;
            bit_ff <= nxt_bit;
            io_ff <= nxt_io;
        end
    end

    // ----------------------------------------
    // sequencer and shift/flag unit hookup
    // ----------------------------------------
    assign ex.start = cmd_wr;
    assign ex.long_op = (op_ff == stack_pop_op) | (op_ff == io_bit_set_op) | (op_ff == io_bit_clear_op);
    assign ex.op = op_ff;
    assign ex.operand = gpr_mem[reg_ff];
    assign ex.flags_in = flags_ff;
    assign ex.bit_sel = bit_ff;

    bsf_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ex(ex.seq_mp)
    );

    bsf_alu u_alu (
        .ex(ex.alu_mp)
    );

    // ----------------------------------------
    // pointers, flags and hold byte
    // ----------------------------------------
    always_comb
    begin
        nxt_gpr_idx = gpr_idx_ff;
        nxt_io_idx = io_idx_ff;
        nxt_sp = sp_ff;
        nxt_hold = hold_ff;
        nxt_flags = flags_ff;
        // index registers stay writable while busy; they steer only bus access
        if (wr_acc & (paddr == GPR_IDX_ADDR))
            nxt_gpr_idx = pwdata[4:0];
        if (wr_acc & (paddr == IO_IDX_ADDR))
            nxt_io_idx = pwdata[5:0];
        if (data_wr & (paddr == SP_ADDR))
            nxt_sp = pwdata[3:0];
        if (data_wr & (paddr == STACK_DATA_ADDR))
            nxt_sp = sp_ff - 4'h1; // push stores then moves down
        if (data_wr & (paddr == FLAGS_ADDR))
            nxt_flags = pwdata[7:0];
        if (ex.stage_a)
        begin
            unique case (op_ff)
                stack_pop_op: nxt_sp = sp_ff + 4'h1;
                io_bit_set_op, io_bit_clear_op: nxt_hold = io_mem[io_ff];
                default: nxt_flags = ex.flags_out;
            endcase
        end
    end

    // pointer and flag registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpr_idx_ff <= 5'h00;
            io_idx_ff <= 6'h00;
            sp_ff <= SP_RESET;
            hold_ff <= 8'h00;
            flags_ff <= FLAGS_RESET;
        end
        else
        begin
            gpr_idx_ff <= nxt_gpr_idx;
            io_idx_ff <= nxt_io_idx;
            sp_ff <= nxt_sp;
            hold_ff <= nxt_hold;
            flags_ff <= nxt_flags;
        end
    end

    // ----------------------------------------
    // storage write ports
    // ----------------------------------------
    // execution owns the stores while busy; the bus only when idle
    always_comb
    begin
        gpr_we = data_wr & (paddr == GPR_DATA_ADDR);
        gpr_wa = gpr_idx_ff;
        gpr_wd = pwdata[7:0];
        io_we = data_wr & (paddr == IO_DATA_ADDR);
        io_wa = io_idx_ff;
        io_wd = pwdata[7:0];
        stack_we = data_wr & (paddr == STACK_DATA_ADDR);
        stack_wa = sp_ff;
        stack_wd = pwdata[7:0];
        if (ex.stage_a)
        begin
            unique case (op_ff)
                logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
                rotate_right_carry_op, arith_right_shift_op, nibble_swap_op,
                transfer_flag_to_bit_op:
                begin
                    gpr_we = 1'b1;
                    gpr_wa = reg_ff;
                    gpr_wd = ex.result;
                end
                default:
                begin
                end
            endcase
        end
        if (ex.stage_b)
        begin
            if (op_ff == stack_pop_op)
            begin
                gpr_we = 1'b1;
                gpr_wa = reg_ff;
                gpr_wd = stack_mem[sp_ff];
            end
            else
            begin
                io_we = 1'b1;
                io_wa = io_ff;
                io_wd = hold_ff;
                io_wd[bit_ff] = (op_ff == io_bit_set_op);
            end
        end
    end

    // storage arrays, no reset so they map onto plain memory
    always_ff @(posedge pclk)
    begin
        if (gpr_we)
            gpr_mem[gpr_wa] <= gpr_wd;
        if (io_we)
            io_mem[io_wa] <= io_wd;
        if (stack_we)
            stack_mem[stack_wa] <= stack_wd;
    end
endmodule

/* bsf_top_properties.sv */
// assertions on the apb ports of the shift/bit/flag datapath
// assumes one pclk domain and zero-wait-state answers from the block
module bsf_checker
    import bsf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic done;
    logic bad_addr;
    logic cmd_short;
    logic cmd_long;
    logic st_rd;

    // --------------------------------
    // decode of the finishing transfer
    // --------------------------------
    assign done = psel && penable && pready;
    assign bad_addr = (paddr > SP_ADDR) || (paddr[1:0] != 2'h0);
    assign st_rd = done && !pwrite && paddr == STATUS_ADDR;
    // nop and codes e/f excluded: they start nothing worth timing
    assign cmd_short = done && pwrite && paddr == CMD_ADDR && pwdata[3:0] >= 4'h4 && pwdata[3:0] <= 4'hd;
    assign cmd_long = done && pwrite && paddr == CMD_ADDR && pwdata[3:0] >= 4'h1 && pwdata[3:0] <= 4'h3;

    // --------------------------------
    // bus answer and operation timing
    // --------------------------------
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    a_err_unmapped: assert property (done && bad_addr |-> pslverr)
        else $error("unmapped address not refused");
    a_err_mapped: assert property (done && !bad_addr |-> !pslverr)
        else $error("mapped address refused");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_err_nodata: assert property (done && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // a status read set up one idle cycle after the command sees the second stage
    a_short_free: assert property (st_rd && $past(cmd_short, 3) |-> !prdata[STATUS_BUSY_BIT])
        else $error("one-cycle operation still busy");
    a_long_busy: assert property (st_rd && $past(cmd_long, 3) |-> prdata[STATUS_BUSY_BIT])
        else $error("two-cycle operation ended early");

    c_long: cover property (st_rd && $past(cmd_long, 3));
    c_short: cover property (st_rd && $past(cmd_short, 3));
    c_refused: cover property (done && pslverr);
endmodule

bind bsf_top bsf_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* apb_master_model.sv */
// apb master standing in for the decode stage that issues operations
// assumes every task is entered just after a rising edge of pclk
module apb_master_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end

    // psel stays up at the end so a setup may follow at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
    endtask

    // released address and data lines show the inverse, not a stale value
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        @(posedge pclk);
    endtask
endmodule

/* test_bit_shift_flag_exec.sv */
// self-checking bench: operations issued and checked over apb
// assumes the master model and the bound checker compile alongside
module test_bit_shift_flag_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import bsf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, flg, res;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] vals [5] = '{8'h81, 8'h80, 8'h01, 8'h00, 8'h5a};
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;

    always #20 pclk = ~pclk;

    bsf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    apb_master_model mst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ----------------
    // helpers
    // ----------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        mst.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a);
        mst.xfer(1'b0, a, 32'h0, q, e);
    endtask

    // poll busy; a hang is cut by the cycle ceiling
    task automatic poll();
        rd(STATUS_ADDR);
        while (q[STATUS_BUSY_BIT] !== 1'b0)
            rd(STATUS_ADDR);
    endtask

    task automatic run(input op_t op, input logic [4:0] r, input logic [2:0] b, input logic [5:0] io);
        wr(CMD_ADDR, {14'h0, io, b, r, op});
        // one idle cycle so the first status read is set up in the second stage
        mst.idle();
        rd(STATUS_ADDR);
        chk({31'h0, q[STATUS_BUSY_BIT]}, {31'h0, op inside {stack_pop_op, io_bit_set_op, io_bit_clear_op}});
        poll();
    endtask

    task automatic gset(input logic [4:0] r, input logic [7:0] v);
        wr(GPR_IDX_ADDR, {27'h0, r});
        wr(GPR_DATA_ADDR, {24'h0, v});
    endtask

    task automatic gget(input logic [4:0] r);
        wr(GPR_IDX_ADDR, {27'h0, r});
        rd(GPR_DATA_ADDR);
    endtask

    task automatic fchk();
        rd(FLAGS_ADDR);
        chk(q, {24'h0, flg});
    endtask

    // expected result and flags of shifts, rotates and swap
    function automatic logic [15:0] model(input logic [3:0] op, input logic [7:0] v, input logic [7:0] f);
        logic [7:0] r;
        logic c;
        c = v[0];
        case (op)
            4'h4: {c, r} = {v, 1'b0};
            4'h5: r = {1'b0, v[7:1]};
            4'h6: {c, r} = {v, f[FLAG_C]};
            4'h7: r = {f[FLAG_C], v[7:1]};
            4'h8: r = {v[7], v[7:1]};
            default: return {v[3:0], v[7:4], f};
        endcase
        f[FLAG_C] = c;
        f[FLAG_Z] = (r == 8'h0);
        f[FLAG_N] = r[7];
        f[FLAG_V] = r[7] ^ c;
        return {r, f};
    endfunction

    // ceiling well above the fewer than one thousand cycles the tests need
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ----------------
    // tests
    // ----------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(FLAGS_ADDR);
        chk(q, {24'h0, FLAGS_RESET});
        rd(SP_ADDR);
        chk(q, {28'h0, SP_RESET});
        rd(8'h24);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        mst.idle();
        $display("reset and unmapped test done");
        // both carry-in levels, boundary operands, top register
        foreach (vals[i])
            for (int k = 4; k <= 9; k++)
            begin
                flg = (i % 2) ? 8'hff : 8'h00;
                wr(FLAGS_ADDR, {24'h0, flg});
                gset(5'h1f, vals[i]);
                run(op_t'(k), 5'h1f, 3'h0, 6'h0);
                {res, flg} = model(k[3:0], vals[i], flg);
                gget(5'h1f);
                chk(q, {24'h0, res});
                fchk();
            end
        mst.idle();
        $display("shift test done");
        flg = 8'h0;
        wr(FLAGS_ADDR, 32'h0);
        gset(5'h03, 8'h20);
        run(bit_to_transfer_flag_op, 5'h03, 3'h5, 6'h0);
        flg[FLAG_T] = 1'b1;
        fchk();
        gset(5'h03, 8'h00);
        run(transfer_flag_to_bit_op, 5'h03, 3'h7, 6'h0);
        gget(5'h03);
        chk(q, 32'h80);
        fchk();
        run(bit_to_transfer_flag_op, 5'h03, 3'h0, 6'h0);
        flg[FLAG_T] = 1'b0;
        fchk();
        mst.idle();
        $display("bit move test done");
        // set every flag in turn, then clear in turn: others must hold
        for (int p = 0; p < 2; p++)
            for (int b = 0; b < 8; b++)
            begin
                run(op_t'(12 + p), 5'h0, b[2:0], 6'h0);
                flg[b] = (p == 0);
                fchk();
                rd(STATUS_ADDR);
                chk(q, {16'h0, flg, 8'h0});
            end
        mst.idle();
        $display("flag test done");
        wr(IO_IDX_ADDR, 32'h3f);
        wr(IO_DATA_ADDR, 32'h5a);
        run(io_bit_set_op, 5'h0, 3'h7, 6'h3f);
        rd(IO_DATA_ADDR);
        chk(q, 32'hda);
        run(io_bit_clear_op, 5'h0, 3'h1, 6'h3f);
        rd(IO_DATA_ADDR);
        chk(q, 32'hd8);
        fchk();
        mst.idle();
        $display("io bit test done");
        // flags write lands while the pop is busy and must be dropped
        wr(STACK_DATA_ADDR, 32'hc3);
        wr(CMD_ADDR, {14'h0, 6'h0, 3'h0, 5'h02, stack_pop_op});
        wr(FLAGS_ADDR, 32'h55);
        poll();
        gget(5'h02);
        chk(q, 32'hc3);
        fchk();
        rd(SP_ADDR);
        chk(q, {28'h0, SP_RESET});
        mst.idle();
        $display("pop test done");
        summarize();
    end
endmodule
